// >>> verilog/spi_port_defines.svh
// Purpose: Register map, field positions, reset values and timing figures of the serial port
// Assumes: Byte-wide register port with a two-bit address
// Notes:   Definitions only
`ifndef SPI_PORT_DEFINES_SVH
`define SPI_PORT_DEFINES_SVH

// ==========================================================
// Register offsets
`define SPI_ADDR_CONTROL     2'h0
`define SPI_ADDR_PRESCALER   2'h1
`define SPI_ADDR_STATUS      2'h2
`define SPI_ADDR_DATA        2'h3

// ==========================================================
// Control register fields
`define CTRL_INT_ENABLE      7
`define CTRL_INT_SELECT      6
`define CTRL_PORT_OE         5
`define CTRL_MASTER          4
`define CTRL_CLK_POLARITY    3
`define CTRL_CLK_PHASE       2
`define CTRL_RATE_HIGH       1
`define CTRL_RATE_LOW        0
`define CTRL_RESET           8'h00

// ==========================================================
// Prescaler register fields
`define PRESC_HALF_RATE      3
`define PRESC_RESET          4'h0

// ==========================================================
// Status register fields
`define STAT_COMPLETE        7
`define STAT_COLLISION       6
`define STAT_MODE_FAULT      4

// ==========================================================
// Transfer shape and clock
`define BITS_PER_BYTE        8
`define EDGES_PER_BYTE       5'h10
`define CLK_PERIOD_NS        4

`endif

// >>> verilog/spi_port_pkg.sv
// Purpose: Types shared by the serial port
// Assumes: Constants live in spi_port_defines.svh
// Notes:   The whole state of the port is one packed struct
package spi_port_pkg;

    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_MASTER_RUN,
        MODE_SLAVE_RUN
    } mode_e;

    typedef struct packed {
        mode_e       mode;
        logic [7:0]  ctrl;
        logic [3:0]  presc;
        logic        tc;
        logic        write_collision_flag;
        logic        mode_fault_flag;
        logic        tc_armed;
        logic        write_collision_flag_armed;
        logic        mode_fault_flag_armed;
        logic [7:0]  shift;
        logic [7:0]  rx_buf;
        logic        out_q;
        logic        sck_q;
        logic [4:0]  edges;
        logic [9:0]  cnt;
        logic [2:0]  sync_sck;
        logic [2:0]  sync_mosi;
        logic [2:0]  sync_miso;
        logic [2:0]  sync_ss;
        logic        sck_f;
        logic        mosi_f;
        logic        miso_f;
        logic        ss_f;
        logic [7:0]  rdata;
    } state_s;

endpackage

// >>> verilog/spi_master_slave_port.sv
// Purpose: Byte-wide full-duplex synchronous serial port, master or slave
// Assumes: One 250 MHz clock; pins pass a three-stage filter before use
// Notes:   Registers reached over a plain strobe port, read data one cycle later
//
// What this block does
// - Each transfer swaps one byte both ways, MSB first, on master's clock.
// - Slave accepts clocks up to a quarter of internal clock; master offers four rate multipliers.
// - Master clock comes from a 3-bit prescaler plus a divide-by-two stage.
// - Baud rate set by half-rate bit, prescaler value and two rate bits.
// - Polarity and phase are software selectable; both ends must match.
// - Master drives clock, drives MOSI, samples MISO.
// - Master needs select high; master and output-enable bits drop otherwise.
// - As master, writing the data register starts a transfer.
// - Written byte loads the shift register, then shifts out MSB first.
// - Transfer end sets the transfer-complete flag.
// - Complete interrupt raised only when interrupt-select and interrupt-enable are set; mode fault needs only enable.
// - At completion received byte copies to a buffer read from data register.
// - Complete flag clears by status access then data register access.
// - Data writes ignored while complete flag set until status is read.
// - Pins drive outputs, and select counts, only when configured as alternate function; SCK, MOSI and MISO inputs are always sampled.
// - One shared shift register; received byte replaces transmitted byte.
// - Polarity sets idle clock level; phase picks first or second capture edge.
// - A byte takes eight clock pulses, shifting out and in together.
// - Data write during transfer is dropped and sets collision flag, no interrupt.
// - Select low in master mode sets mode fault, clears master and enable.
`timescale 1ns/10ps
`include "spi_port_defines.svh"

module spi_master_slave_port #(
    parameter int unsigned RATE_MULT_0 = 4,
    parameter int unsigned RATE_MULT_1 = 8,
    parameter int unsigned RATE_MULT_2 = 16,
    parameter int unsigned RATE_MULT_3 = 32
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output      logic [7:0] rdata,
    output      logic       irq,
    input  wire logic       af_sck,
    input  wire logic       af_mosi,
    input  wire logic       af_miso,
    input  wire logic       af_ss,
    input  wire logic       sck_in,
    output      logic       sck_out,
    output      logic       sck_oe,
    input  wire logic       mosi_in,
    output      logic       mosi_out,
    output      logic       mosi_oe,
    input  wire logic       miso_in,
    output      logic       miso_out,
    output      logic       miso_oe,
    input  wire logic       ss_n
);

    spi_port_pkg::state_s s;
    spi_port_pkg::state_s next_s;

    // ==========================================================
    // Helpers

    // Half SCK period in clk cycles; never below one cycle
    function automatic logic [9:0] half_period(input logic [2:0] pre, input logic half,
                                               input logic [1:0] rate);
        logic [9:0] mult;
        logic [9:0] base;
        case (rate)
            2'h0:    mult = 10'(RATE_MULT_0);
            2'h1:    mult = 10'(RATE_MULT_1);
            2'h2:    mult = 10'(RATE_MULT_2);
            default: mult = 10'(RATE_MULT_3);
        endcase
        base = 10'({7'h00, pre} + 10'h001) * mult;
        half_period = half ? 10'(base << 1) : base;
    endfunction

    // One SCK edge: launch puts MSB on the line, capture shifts the input in
    function automatic logic [8:0] edge_step(input logic [7:0] sh, input logic out,
                                             input logic odd, input logic clock_phase_bit,
                                             input logic din);
        if (odd == clock_phase_bit) begin
            edge_step = {sh[7], sh};
        end else begin
            edge_step = {out, sh[6:0], din};
        end
    endfunction

    // Three-stage filter: a change counts once stages two and three agree
    function automatic logic filt(input logic [2:0] sy, input logic f);
        filt = (sy[1] == sy[2]) ? sy[2] : f;
    endfunction

    // ==========================================================
    // Next-state logic
    logic       ie;
    logic       isel;
    logic       poe;
    logic       master_select_bit;
    logic       clock_polarity_bit;
    logic       clock_phase_bit;
    logic       ss_low;
    logic       sck_edge;
    logic       dr_wr;
    logic       dr_acc;
    logic       st_acc;
    logic       busy;
    logic       done;
    logic [8:0] step;

    assign ie     = s.ctrl[`CTRL_INT_ENABLE];
    assign isel   = s.ctrl[`CTRL_INT_SELECT];
    assign poe    = s.ctrl[`CTRL_PORT_OE];
    assign master_select_bit   = s.ctrl[`CTRL_MASTER];
    assign clock_polarity_bit   = s.ctrl[`CTRL_CLK_POLARITY];
    assign clock_phase_bit   = s.ctrl[`CTRL_CLK_PHASE];
    assign ss_low = af_ss && !s.ss_f;
    assign dr_wr  = wr && addr == `SPI_ADDR_DATA;
    assign dr_acc = (wr || rd) && addr == `SPI_ADDR_DATA;
    assign st_acc = (wr || rd) && addr == `SPI_ADDR_STATUS;
    assign busy   = s.mode != spi_port_pkg::MODE_IDLE;
    assign sck_edge = s.sync_sck[1] == s.sync_sck[2] && s.sync_sck[2] != s.sck_f;

    always_comb begin
        next_s = s;
        done   = 1'b0;
        step   = 9'h000;
        next_s.sync_sck  = {s.sync_sck[1:0], sck_in};
        next_s.sync_mosi = {s.sync_mosi[1:0], mosi_in};
        next_s.sync_miso = {s.sync_miso[1:0], miso_in};
        next_s.sync_ss   = {s.sync_ss[1:0], ss_n};
        next_s.sck_f  = filt(s.sync_sck, s.sck_f);
        next_s.mosi_f = filt(s.sync_mosi, s.mosi_f);
        next_s.miso_f = filt(s.sync_miso, s.miso_f);
        next_s.ss_f   = filt(s.sync_ss, s.ss_f);

        // Clear sequences first so a hardware set in the same cycle wins
        if (st_acc && s.tc) next_s.tc_armed = 1'b1;
        if (st_acc && s.write_collision_flag) next_s.write_collision_flag_armed = 1'b1;
        if (st_acc && s.mode_fault_flag) next_s.mode_fault_flag_armed = 1'b1;
        if (dr_acc && s.tc_armed) begin
            next_s.tc       = 1'b0;
            next_s.tc_armed = 1'b0;
        end
        if (dr_acc && s.write_collision_flag_armed) begin
            next_s.write_collision_flag       = 1'b0;
            next_s.write_collision_flag_armed = 1'b0;
        end

        // Register writes; master and enable bits cannot be set under a fault
        if (wr && addr == `SPI_ADDR_CONTROL) begin
            next_s.ctrl = wdata;
            if (s.mode_fault_flag && !s.mode_fault_flag_armed) begin
                next_s.ctrl[`CTRL_MASTER]  = 1'b0;
                next_s.ctrl[`CTRL_PORT_OE] = 1'b0;
            end
            if (s.mode_fault_flag_armed) begin
                next_s.mode_fault_flag       = 1'b0;
                next_s.mode_fault_flag_armed = 1'b0;
            end
        end
        if (wr && addr == `SPI_ADDR_PRESCALER) next_s.presc = wdata[3:0];

        // Idle line follows the next MSB so phase-0 data is valid before edge one
        if (s.edges == 5'h00) next_s.out_q = s.shift[7];

        case (s.mode)
            spi_port_pkg::MODE_IDLE: begin
                next_s.sck_q = next_s.ctrl[`CTRL_CLK_POLARITY];
                next_s.cnt   = half_period(s.presc[2:0], s.presc[`PRESC_HALF_RATE],
                                           s.ctrl[1:0]);
                if (!master_select_bit && poe && ss_low) next_s.mode = spi_port_pkg::MODE_SLAVE_RUN;
            end
            spi_port_pkg::MODE_MASTER_RUN: begin
                if (s.cnt > 10'h001) begin
                    next_s.cnt = s.cnt - 10'h001;
                end else begin
                    next_s.cnt   = half_period(s.presc[2:0], s.presc[`PRESC_HALF_RATE],
                                               s.ctrl[1:0]);
                    next_s.sck_q = !s.sck_q;
                    next_s.edges = s.edges + 5'h01;
                    step = edge_step(s.shift, s.out_q, !s.edges[0], clock_phase_bit, s.miso_f);
                    next_s.out_q = step[8];
                    next_s.shift = step[7:0];
                    if (next_s.edges == `EDGES_PER_BYTE) begin
                        done         = 1'b1;
                        next_s.edges = 5'h00;
                        next_s.mode  = spi_port_pkg::MODE_IDLE;
                    end
                end
            end
            spi_port_pkg::MODE_SLAVE_RUN: begin
                next_s.sck_q = next_s.ctrl[`CTRL_CLK_POLARITY];
                if (!ss_low || master_select_bit || !poe) begin
                    next_s.edges = 5'h00;
                    next_s.mode  = spi_port_pkg::MODE_IDLE;
                end else if (sck_edge) begin
                    next_s.edges = s.edges + 5'h01;
                    step = edge_step(s.shift, s.out_q, !s.edges[0], clock_phase_bit, s.mosi_f);
                    next_s.out_q = step[8];
                    next_s.shift = step[7:0];
                    if (next_s.edges == `EDGES_PER_BYTE) begin
                        done         = 1'b1;
                        next_s.edges = 5'h00;
                    end
                end
            end
            default: begin
                next_s.mode = spi_port_pkg::MODE_IDLE;
            end
        endcase

        if (done) begin
            next_s.tc       = 1'b1;
            next_s.tc_armed = 1'b0;
            next_s.rx_buf   = next_s.shift;
            next_s.sck_q    = next_s.ctrl[`CTRL_CLK_POLARITY];
        end

        // Data register write: collision, inhibit, or load
        if (dr_wr) begin
            if (busy) begin
                next_s.write_collision_flag = 1'b1;
            end else if (!(s.tc && !s.tc_armed)) begin
                next_s.shift = wdata;
                if (master_select_bit && poe) begin
                    next_s.mode = spi_port_pkg::MODE_MASTER_RUN;
                    next_s.cnt  = half_period(s.presc[2:0], s.presc[`PRESC_HALF_RATE],
                                              s.ctrl[1:0]);
                end
            end
        end

        // Select pulled low under a master aborts and drops to slave
        if (master_select_bit && ss_low) begin
            next_s.mode_fault_flag                 = 1'b1;
            next_s.mode_fault_flag_armed           = 1'b0;
            next_s.ctrl[`CTRL_MASTER]   = 1'b0;
            next_s.ctrl[`CTRL_PORT_OE]  = 1'b0;
            next_s.mode                 = spi_port_pkg::MODE_IDLE;
            next_s.edges                = 5'h00;
            next_s.sck_q                = clock_polarity_bit;
        end

        case (addr)
            `SPI_ADDR_CONTROL:   next_s.rdata = s.ctrl;
            `SPI_ADDR_PRESCALER: next_s.rdata = {4'h0, s.presc};
            `SPI_ADDR_STATUS:    next_s.rdata = {s.tc, s.write_collision_flag, 1'b0, s.mode_fault_flag, 4'h0};
            default:             next_s.rdata = s.rx_buf;
        endcase
        if (!rd) next_s.rdata = 8'h00;
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s           <= '0;
            s.sync_ss   <= 3'h7;
            s.ss_f      <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs; pins drive only when set as alternate function
    assign rdata    = s.rdata;
    assign irq      = ie && ((s.tc && isel) || s.mode_fault_flag);
    assign sck_out  = s.sck_q;
    assign mosi_out = s.out_q;
    assign miso_out = s.out_q;
    assign sck_oe   = af_sck && poe && master_select_bit;
    assign mosi_oe  = af_mosi && poe && master_select_bit;
    assign miso_oe  = af_miso && poe && !master_select_bit && ss_low;

    // ==========================================================
    // Checks
    sequence s_master_end;
        s.mode == spi_port_pkg::MODE_MASTER_RUN && !(master_select_bit && ss_low)
        ##1 s.mode == spi_port_pkg::MODE_IDLE;
    endsequence

    property p_idle_sck;
        @(posedge clk) disable iff (!reset_n)
        (s.mode == spi_port_pkg::MODE_IDLE && $stable(clock_polarity_bit)) |-> sck_out == clock_polarity_bit;
    endproperty
    a_idle_sck: assert property (p_idle_sck) else $error("sck not at idle level");

    property p_start;
        @(posedge clk) disable iff (!reset_n)
        (dr_wr && !busy && master_select_bit && poe && !ss_low && !(s.tc && !s.tc_armed))
        |=> s.mode == spi_port_pkg::MODE_MASTER_RUN && s.shift == $past(wdata);
    endproperty
    a_start: assert property (p_start) else $error("write did not start master");

    property p_complete;
        @(posedge clk) disable iff (!reset_n)
        s_master_end |-> s.tc && s.rx_buf == s.shift;
    endproperty
    a_complete: assert property (p_complete) else $error("completion not flagged");

    property p_collision;
        @(posedge clk) disable iff (!reset_n)
        (dr_wr && busy && !(master_select_bit && ss_low))
        |=> s.write_collision_flag && (s.mode != spi_port_pkg::MODE_IDLE || $past(done) ||
                       $past(s.mode) == spi_port_pkg::MODE_SLAVE_RUN);
    endproperty
    a_collision: assert property (p_collision) else $error("collision missed");

    property p_fault;
        @(posedge clk) disable iff (!reset_n)
        (master_select_bit && ss_low) |=> s.mode_fault_flag && !master_select_bit && !poe && !sck_oe;
    endproperty
    a_fault: assert property (p_fault) else $error("mode fault not taken");

    property p_tc_clear;
        @(posedge clk) disable iff (!reset_n)
        (s.tc && s.tc_armed && dr_acc && !done) |=> !s.tc;
    endproperty
    a_tc_clear: assert property (p_tc_clear) else $error("complete flag not cleared");

    property p_inhibit;
        @(posedge clk) disable iff (!reset_n)
        (dr_wr && !busy && s.tc && !s.tc_armed) |=> $stable(s.shift) && !busy;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibited write accepted");

    property p_irq;
        @(posedge clk) disable iff (!reset_n)
        (s.tc && !s.mode_fault_flag) |-> irq == (ie && isel);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt gating wrong");

    property p_byte_len;
        @(posedge clk) disable iff (!reset_n)
        done |-> $past(s.edges) == 5'h0f;
    endproperty
    a_byte_len: assert property (p_byte_len) else $error("byte not sixteen edges");

endmodule

// >>> sim/spi_far_slave.sv
// Purpose: Behavioural SPI slave standing on the far side of the port's link
// Assumes: Frame bounded by active; master clock seen as plain wire level
// Notes:   Released MISO shows the inverse of its last bit, never a stale value
`timescale 1ns/10ps

module spi_far_slave (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       active,
    input  wire logic       clock_phase_bit,
    input  wire logic [7:0] tx_byte,
    output      logic       miso,
    output      logic [7:0] rx_byte
);
    int edges;
    int idx;

    initial begin
        miso = 1'b0;
        rx_byte = 8'h00;
        edges = 0;
    end

    // ==========================================================
    // Frame start and release
    always @(posedge active) begin
        edges = 0;
        rx_byte = 8'h00;
        miso = tx_byte[7];
    end

    always @(negedge active) begin
        miso = ~miso;
    end

    // ==========================================================
    // Odd edges capture with phase clear, even edges with phase set
    always @(sck) begin
        if (active) begin
            edges = edges + 1;
            if (((edges % 2) == 1) != clock_phase_bit) begin
                rx_byte = {rx_byte[6:0], mosi};
            end else if (edges < 16) begin
                idx = clock_phase_bit ? (edges - 1) / 2 : edges / 2;
                miso = tx_byte[7 - idx];
            end
        end
    end
endmodule

// >>> sim/tb_spi_master_slave_port.sv
// Purpose: Self-checking bench of the serial port in master and slave roles
// Assumes: Default rate multipliers; far side is a behavioural slave
// Notes:   Random bytes and rates from a fixed seed, corners mixed in
`timescale 1ns/10ps
`include "spi_port_defines.svh"

module tb_spi_master_slave_port;
    logic       clk;
    logic       reset_n;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       irq;
    logic       af_sck;
    logic       ss_n;
    logic       host_sck;
    logic       host_mosi;
    logic       sck_out;
    logic       sck_oe;
    logic       mosi_out;
    logic       mosi_oe;
    logic       miso_out;
    logic       miso_oe;
    logic       far_miso;
    logic       far_active;
    logic       far_clock_phase_bit;
    logic [7:0] far_tx;
    logic [7:0] far_rx;
    wire        sck_w  = sck_oe ? sck_out : host_sck;
    wire        mosi_w = mosi_oe ? mosi_out : host_mosi;
    wire        miso_w = miso_oe ? miso_out : far_miso;
    int         failures;
    int         comparisons;

    spi_master_slave_port dut_u (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .af_sck(af_sck), .af_mosi(af_sck),
        .af_miso(1'b1), .af_ss(1'b1), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
        .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
        .miso_out(miso_out), .miso_oe(miso_oe), .ss_n(ss_n));

    spi_far_slave far_u (.sck(sck_w), .mosi(mosi_w), .active(far_active), .clock_phase_bit(far_clock_phase_bit),
        .tx_byte(far_tx), .miso(far_miso), .rx_byte(far_rx));

    always #2 clk = ~clk;

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp, input string msg);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp, msg);
    endtask

    function automatic int half_period(input logic [2:0] p, input logic [1:0] r,
                                       input logic hf);
        return (int'(p) + 1) * (4 << r) * (hf ? 2 : 1);
    endfunction

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========================================================
    // Watchdog: slowest rates keep the run under 15000 cycles
    initial begin
        #120000;
        failures++;
        conclude();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [2:0] p;
        logic [1:0] r;
        logic       hf;
        logic       clock_polarity_bit;
        logic       clock_phase_bit;
        logic       isel;
        logic       last;
        logic [7:0] mb;
        logic [7:0] sb;
        int         h;
        int         toggles;
        clk = 1'b0;
        reset_n = 1'b0;
        addr = 2'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        af_sck = 1'b1;
        ss_n = 1'b1;
        host_sck = 1'b0;
        host_mosi = 1'b1;
        far_active = 1'b0;
        far_clock_phase_bit = 1'b0;
        far_tx = 8'h00;
        failures = 0;
        comparisons = 0;
        void'($urandom(32'h1385));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        #1 check({7'h00, sck_out}, 8'h00, "idle clock");
        check({7'h00, irq}, 8'h00, "irq after reset");
        rd_chk(`SPI_ADDR_CONTROL, 8'h00, "control reset");
        rd_chk(`SPI_ADDR_PRESCALER, 8'h00, "prescaler reset");
        rd_chk(`SPI_ADDR_STATUS, 8'h00, "status reset");
        $display("test reset done");

        // Every polarity and phase, random rate and bytes, with a collision
        for (int m = 0; m < 4; m++) begin
            {clock_polarity_bit, clock_phase_bit} = 2'(m);
            isel = clock_polarity_bit;
            p = 3'($urandom_range(2, 1));
            r = 2'($urandom_range(3, 0));
            hf = 1'($urandom_range(1, 0));
            mb = (m == 0) ? 8'h80 : 8'($urandom);
            sb = (m == 3) ? 8'h01 : 8'($urandom);
            h = half_period(p, r, hf);
            wr_reg(`SPI_ADDR_PRESCALER, {4'h0, hf, p});
            wr_reg(`SPI_ADDR_CONTROL, {1'b1, isel, 2'b11, clock_polarity_bit, clock_phase_bit, r});
            far_tx <= sb;
            far_clock_phase_bit <= clock_phase_bit;
            @(posedge clk);
            far_active <= 1'b1;
            #1 check({7'h00, sck_out}, {7'h00, clock_polarity_bit}, "idle level");
            wr_reg(`SPI_ADDR_DATA, mb);
            wr_reg(`SPI_ADDR_DATA, ~mb);
            toggles = 0;
            last = clock_polarity_bit;
            repeat (17 * h + 8) begin
                @(posedge clk);
                #1;
                if (sck_out !== last) begin
                    toggles++;
                    last = sck_out;
                end
            end
            check(8'(toggles), 8'h10, "clock toggles");
            wr_reg(`SPI_ADDR_DATA, 8'h5a);
            repeat (h + 2) @(posedge clk);
            #1 check({7'h00, sck_out}, {7'h00, clock_polarity_bit}, "no restart");
            check({7'h00, irq}, {7'h00, isel}, "irq gate");
            rd_chk(`SPI_ADDR_STATUS, 8'hc0, "done and collision");
            rd_chk(`SPI_ADDR_DATA, sb, "received byte");
            check(far_rx, mb, "sent byte");
            rd_chk(`SPI_ADDR_STATUS, 8'h00, "flags cleared");
            @(posedge clk);
            far_active <= 1'b0;
            $display("test transfer mode %0d done", m);
        end

        // Pin routing and master mode fault
        wr_reg(`SPI_ADDR_CONTROL, 8'hb0);
        repeat (2) @(posedge clk);
        #1 check({7'h00, sck_oe}, 8'h01, "clock driven");
        check({7'h00, mosi_oe}, 8'h01, "data out driven");
        @(posedge clk);
        af_sck <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check({7'h00, sck_oe}, 8'h00, "clock pin not routed");
        check({7'h00, mosi_oe}, 8'h00, "data pin not routed");
        @(posedge clk);
        af_sck <= 1'b1;
        ss_n <= 1'b0;
        repeat (8) @(posedge clk);
        #1 check({7'h00, irq}, 8'h01, "fault irq");
        check({7'h00, sck_oe}, 8'h00, "fault releases clock");
        rd_chk(`SPI_ADDR_STATUS, 8'h10, "fault flag");
        rd_chk(`SPI_ADDR_CONTROL, 8'h80, "fault drops master");
        @(posedge clk);
        ss_n <= 1'b1;
        repeat (6) @(posedge clk);
        wr_reg(`SPI_ADDR_CONTROL, 8'h00);
        rd_chk(`SPI_ADDR_STATUS, 8'h00, "fault cleared");
        $display("test mode fault done");

        // Slave role, phase 0: host clock edges spaced well beyond the pin filter
        mb = 8'($urandom);
        sb = 8'($urandom);
        wr_reg(`SPI_ADDR_CONTROL, 8'h20);
        wr_reg(`SPI_ADDR_DATA, mb);
        ss_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1 check({7'h00, miso_oe}, 8'h01, "slave drives data out");
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk);
            host_mosi <= sb[i];
            repeat (5) @(posedge clk);
            #1 check({7'h00, miso_out}, {7'h00, mb[i]}, "slave bit out");
            @(posedge clk);
            host_sck <= 1'b1;
            repeat (6) @(posedge clk);
            host_sck <= 1'b0;
            repeat (5) @(posedge clk);
        end
        #1 check({7'h00, irq}, 8'h00, "no irq when disabled");
        rd_chk(`SPI_ADDR_STATUS, 8'h80, "slave byte done");
        rd_chk(`SPI_ADDR_DATA, sb, "slave received byte");
        @(posedge clk);
        ss_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1 check({7'h00, miso_oe}, 8'h00, "slave releases data out");
        $display("test slave role done");
        conclude();
    end
endmodule
